// ==== rtl/rfs_pkg.sv ====
// Package for the reader configuration and sync-bus controller.
// Assumes a 100 MHz core clock and an APB master with 32-bit data.
package rfs_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1_000_000;
	localparam int MS_CYC_DEF = MS_NS / CLK_PERIOD_NS;
	localparam int SYNC_PULSE_NS = 1000;
	localparam int SYNC_PULSE_CYC = SYNC_PULSE_NS / CLK_PERIOD_NS;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_RANGE = 8'h04;
	localparam logic [7:0] OFF_ATTEN = 8'h08;
	localparam logic [7:0] OFF_FREQ = 8'h0c;
	localparam logic [7:0] OFF_SYNC = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_CTRL = 8'h18;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CMD_OP_LSB = 16;
	localparam int HI_FIELD_LSB = 8;
	localparam int CTRL_IAG_BIT = 0;
	localparam int CTRL_OTH_BIT = 1;
	localparam int CTRL_RF_BIT = 2;
	localparam int STAT_CORRUPT_BIT = 4;
	localparam int STAT_RF_BIT = 5;
	localparam int STAT_FSM_LSB = 8;

	// ----------------------------------------
	// Limits and reset values
	// ----------------------------------------
	localparam logic [11:0] RANGE_MAX = 12'h01f;
	localparam logic [11:0] ATT_MAX = 12'h00a;
	localparam logic [11:0] TOLL_MAX = 12'h00f;
	localparam logic [11:0] FREQ_MAX = 12'h118;
	localparam logic [11:0] DELAY_MAX = 12'h0ff;
	localparam logic [11:0] HOLD_MAX = 12'h00a;
	localparam logic [4:0] RANGE_RST = 5'h1f;
	localparam logic [3:0] ATT_RST = 4'h0;
	localparam logic [3:0] TOLL_RST = 4'h4;
	localparam logic [8:0] FREQ_RST = 9'h000;
	localparam logic [7:0] DELAY_RST = 8'h00;
	localparam logic [7:0] HOLD_RST = 8'h00;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [3:0] {
		set_rail_tag_range_cmd = 4'h1,
		set_rf_atten_cmd = 4'h2,
		set_second_family_range_cmd = 4'h3,
		set_toll_atten_cmd = 4'h4,
		set_carrier_freq_cmd = 4'h5,
		set_sync_delay_cmd = 4'h6,
		set_sync_holdoff_cmd = 4'h7,
		show_sync_cmd = 4'h8
	} rfs_op_e;

	typedef enum logic [3:0] {
		resp_none = 4'h0,
		resp_done = 4'h1,
		resp_error = 4'h2,
		freq_store_corrupt_error = 4'h6
	} rfs_resp_e;

	typedef enum logic [2:0] {
		st_count = 3'b001,
		st_hold = 3'b010,
		st_run = 3'b100
	} rfs_sync_e;

	typedef struct packed {
		logic [4:0] rail_range;
		logic [3:0] rf_atten;
		logic [4:0] sec_range;
		logic [3:0] toll_atten;
		logic [8:0] freq_code;
		logic [7:0] sync_delay;
		logic [7:0] sync_holdoff;
		logic iag_en;
		logic oth_en;
	} rfs_cfg_s;

endpackage

// ==== rtl/rfs_ctrl.sv ====
// Reader configuration command interpreter and multi-reader sync-bus timer.
// Assumes an APB master, a persistent frequency store with an integrity flag,
// and a tag protocol engine that reports completion with a one-cycle pulse.
`timescale 1ns/1ps
module rfs_ctrl #(
	parameter int MS_CYC = rfs_pkg::MS_CYC_DEF
) (
	input wire logic core_clk, // System clock.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic ce, // Clock enable, freezes all state when low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB direction.
	input wire logic [7:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error on unmapped address.
	input wire logic sync_in, // Sync bus receive level.
	output logic sync_out, // Sync bus drive level.
	output logic sync_oe, // Sync bus driver enable.
	input wire logic rf_sensor_req, // External sensor RF enable request.
	input wire logic [8:0] nv_freq, // Stored frequency code.
	input wire logic nv_ok, // Stored frequency passes integrity check.
	output logic nv_wr, // Store write strobe.
	output logic [8:0] nv_wdata, // Store write data.
	input wire logic prot_done, // Tag protocols finished.
	output logic tag_start, // Start enabled tag protocols.
	output logic iag_start, // Start the IAG tag sequence.
	output logic rf_en, // RF section enable.
	output logic resp_valid, // Host reply strobe.
	output logic [3:0] resp_code, // Host reply code.
	output rfs_pkg::rfs_cfg_s cfg // Current settings.
);
	import rfs_pkg::*;

	typedef struct packed {
		rfs_cfg_s cfg;
		logic booted;
		logic corrupt;
		logic rf_on;
		logic rf_en;
		logic sensor_d;
		logic sync_in_d;
		logic [16:0] cyc;
		logic [7:0] ms;
		logic [7:0] pcnt;
		rfs_sync_e fsm;
		logic sync_oe;
		logic tag_start;
		logic iag_start;
		logic nv_wr;
		logic [8:0] nv_wdata;
		logic resp_valid;
		logic [3:0] resp_code;
		logic [3:0] last_resp;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} rfs_state_s;

	localparam rfs_cfg_s CFG_RST = '{
		rail_range: RANGE_RST, rf_atten: ATT_RST, sec_range: RANGE_RST,
		toll_atten: TOLL_RST, freq_code: FREQ_RST, sync_delay: DELAY_RST,
		sync_holdoff: HOLD_RST, iag_en: 1'b0, oth_en: 1'b0};

	localparam rfs_state_s ST_RST = '{
		cfg: CFG_RST, fsm: st_count, resp_code: resp_none, last_resp: resp_none,
		default: '0};

	rfs_state_s s;
	rfs_state_s next_s;

	logic setup;
	logic acc_wr;
	logic ms_tick;
	logic sync_rise;
	logic rf_try;
	logic cmd_ok;
	logic [11:0] val;
	logic [3:0] op;

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.tag_start = 1'b0;
		next_s.iag_start = 1'b0;
		next_s.nv_wr = 1'b0;
		next_s.resp_valid = 1'b0;
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		next_s.sensor_d = rf_sensor_req;
		next_s.sync_in_d = sync_in;
		setup = psel && !penable;
		acc_wr = psel && penable && s.pready && pwrite;
		op = pwdata[CMD_OP_LSB +: 4];
		val = pwdata[11:0];
		cmd_ok = 1'b0;
		rf_try = rf_sensor_req && !s.sensor_d;
		sync_rise = sync_in && !s.sync_in_d && !s.sync_oe;
		ms_tick = (s.cyc == 17'(MS_CYC - 1));

		if (!s.booted) begin
			next_s.booted = 1'b1;
			next_s.cfg.freq_code = nv_freq;
			next_s.corrupt = !nv_ok;
			if (!nv_ok) begin
				next_s.resp_valid = 1'b1;
				next_s.resp_code = freq_store_corrupt_error;
			end
		end

		// APB setup phase answers in the following access cycle.
		if (setup) begin
			next_s.pready = 1'b1;
			next_s.prdata = '0;
			case (paddr)
				OFF_CMD: next_s.prdata = '0;
				OFF_RANGE: begin
					next_s.prdata[4:0] = s.cfg.rail_range;
					next_s.prdata[HI_FIELD_LSB +: 5] = s.cfg.sec_range;
				end
				OFF_ATTEN: begin
					next_s.prdata[3:0] = s.cfg.rf_atten;
					next_s.prdata[HI_FIELD_LSB +: 4] = s.cfg.toll_atten;
				end
				OFF_FREQ: next_s.prdata[8:0] = s.cfg.freq_code;
				OFF_SYNC: begin
					next_s.prdata[7:0] = s.cfg.sync_delay;
					next_s.prdata[HI_FIELD_LSB +: 8] = s.cfg.sync_holdoff;
				end
				OFF_STATUS: begin
					next_s.prdata[3:0] = s.last_resp;
					next_s.prdata[STAT_CORRUPT_BIT] = s.corrupt;
					next_s.prdata[STAT_RF_BIT] = s.rf_en;
					next_s.prdata[STAT_FSM_LSB +: 3] = s.fsm;
				end
				OFF_CTRL: begin
					next_s.prdata[CTRL_IAG_BIT] = s.cfg.iag_en;
					next_s.prdata[CTRL_OTH_BIT] = s.cfg.oth_en;
					next_s.prdata[CTRL_RF_BIT] = s.rf_on;
				end
				default: next_s.pslverr = 1'b1;
			endcase
		end

		if (acc_wr && paddr == OFF_CTRL) begin
			next_s.cfg.iag_en = pwdata[CTRL_IAG_BIT];
			next_s.cfg.oth_en = pwdata[CTRL_OTH_BIT];
			next_s.rf_on = pwdata[CTRL_RF_BIT];
			rf_try = rf_try || (pwdata[CTRL_RF_BIT] && !s.rf_on);
		end

		if (rf_try) begin
			next_s.rf_on = 1'b1;
			if (s.corrupt) begin
				next_s.resp_valid = 1'b1;
				next_s.resp_code = freq_store_corrupt_error;
			end
		end

		// Host command response takes priority over a sensor report.
		if (acc_wr && paddr == OFF_CMD) begin
			case (op)
				set_rail_tag_range_cmd: if (val <= RANGE_MAX) begin
					cmd_ok = 1'b1;
					next_s.cfg.rail_range = val[4:0];
				end
				set_rf_atten_cmd: if (val <= ATT_MAX) begin
					cmd_ok = 1'b1;
					next_s.cfg.rf_atten = val[3:0];
				end
				set_second_family_range_cmd: if (val <= RANGE_MAX) begin
					cmd_ok = 1'b1;
					next_s.cfg.sec_range = val[4:0];
				end
				set_toll_atten_cmd: if (val <= TOLL_MAX) begin
					cmd_ok = 1'b1;
					next_s.cfg.toll_atten = val[3:0];
				end
				set_carrier_freq_cmd: if (val <= FREQ_MAX) begin
					cmd_ok = 1'b1;
					next_s.cfg.freq_code = val[8:0];
					next_s.nv_wr = 1'b1;
					next_s.nv_wdata = val[8:0];
					next_s.corrupt = 1'b0;
				end
				set_sync_delay_cmd: if (val <= DELAY_MAX) begin
					cmd_ok = 1'b1;
					next_s.cfg.sync_delay = val[7:0];
				end
				set_sync_holdoff_cmd: if (val <= HOLD_MAX) begin
					cmd_ok = 1'b1;
					next_s.cfg.sync_holdoff = val[7:0];
				end
				show_sync_cmd: cmd_ok = 1'b1;
				default: cmd_ok = 1'b0;
			endcase
			next_s.resp_valid = 1'b1;
			next_s.resp_code = cmd_ok ? resp_done : resp_error;
		end
		if (next_s.resp_valid) begin
			next_s.last_resp = next_s.resp_code;
		end
		next_s.rf_en = next_s.rf_on && !next_s.corrupt;

		// Sync bus driver stretches its pulse for a fixed width.
		if (s.pcnt != 8'h00) begin
			next_s.pcnt = s.pcnt - 8'h01;
		end
		next_s.sync_oe = (next_s.pcnt != 8'h00);
		next_s.cyc = ms_tick ? 17'h0_0000 : s.cyc + 17'h0_0001;

		case (s.fsm)
			st_count: begin
				if (s.cfg.sync_delay == 8'h00) begin
					next_s.cyc = '0;
					next_s.ms = '0;
				// A delay lowered mid-count fires at the next tick instead of wrapping.
				end else if (sync_rise || (ms_tick && s.ms + 8'h01 >= s.cfg.sync_delay)) begin
					if (!sync_rise) begin
						next_s.pcnt = 8'(SYNC_PULSE_CYC);
						next_s.sync_oe = 1'b1;
					end
					next_s.tag_start = 1'b1;
					next_s.cyc = '0;
					next_s.ms = '0;
					if (s.cfg.iag_en && s.cfg.sync_holdoff != 8'h00) begin
						next_s.fsm = st_hold;
					end else begin
						next_s.iag_start = s.cfg.iag_en;
						next_s.fsm = (s.cfg.iag_en || s.cfg.oth_en) ? st_run : st_count;
					end
				end else if (ms_tick) begin
					next_s.ms = s.ms + 8'h01;
				end
			end
			st_hold: begin
				if (ms_tick && s.ms + 8'h01 >= s.cfg.sync_holdoff) begin
					next_s.iag_start = 1'b1;
					next_s.fsm = st_run;
				end else if (ms_tick) begin
					next_s.ms = s.ms + 8'h01;
				end
			end
			st_run: begin
				next_s.cyc = '0;
				next_s.ms = '0;
				if (prot_done) begin
					next_s.fsm = st_count;
				end
			end
			default: next_s.fsm = st_count;
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s <= ST_RST;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign sync_out = s.sync_oe;
	assign sync_oe = s.sync_oe;
	assign nv_wr = s.nv_wr;
	assign nv_wdata = s.nv_wdata;
	assign tag_start = s.tag_start;
	assign iag_start = s.iag_start;
	assign rf_en = s.rf_en;
	assign resp_valid = s.resp_valid;
	assign resp_code = s.resp_code;
	assign cfg = s.cfg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n || !ce);

	property p_rail;
		acc_wr && paddr == OFF_CMD && op == set_rail_tag_range_cmd && val > RANGE_MAX
			|=> $stable(cfg.rail_range) && resp_code == resp_error;
	endproperty
	a_rail: assert property (p_rail) else $error("range out of bounds");

	property p_att;
		acc_wr && paddr == OFF_CMD && op == set_rf_atten_cmd && val > ATT_MAX
			|=> $stable(cfg.rf_atten) && resp_code == resp_error;
	endproperty
	a_att: assert property (p_att) else $error("bad attenuation accepted");

	property p_toll;
		acc_wr && paddr == OFF_CMD && op == set_toll_atten_cmd && val <= TOLL_MAX
			|=> cfg.toll_atten == $past(val[3:0]) && resp_code == resp_done;
	endproperty
	a_toll: assert property (p_toll) else $error("toll attenuation not taken");

	property p_nv;
		nv_wr |-> nv_wdata == cfg.freq_code && cfg.freq_code <= FREQ_MAX[8:0];
	endproperty
	a_nv: assert property (p_nv) else $error("store write mismatch");

	property p_corrupt;
		s.corrupt |-> !rf_en;
	endproperty
	a_corrupt: assert property (p_corrupt) else $error("RF on while corrupt");

	property p_retry;
		s.corrupt && rf_try && !(acc_wr && paddr == OFF_CMD)
			|=> resp_valid && resp_code == freq_store_corrupt_error;
	endproperty
	a_retry: assert property (p_retry) else $error("corrupt retry not reported");

	property p_off;
		s.fsm == st_count && cfg.sync_delay == 8'h00 |=> !tag_start;
	endproperty
	a_off: assert property (p_off) else $error("sync ran while disabled");

	property p_pulse;
		$rose(sync_oe) |-> tag_start ##1 sync_oe [*8];
	endproperty
	a_pulse: assert property (p_pulse) else $error("sync pulse malformed");

	property p_hold;
		tag_start && $past(cfg.iag_en) && $past(cfg.sync_holdoff) == 8'h00 |-> iag_start;
	endproperty
	a_hold: assert property (p_hold) else $error("IAG start delayed");

	property p_ack;
		acc_wr && paddr == OFF_CMD |=> resp_valid ##1 !resp_valid;
	endproperty
	a_ack: assert property (p_ack) else $error("no command reply");

endmodule

// ==== tb/rfs_peer.sv ====
// Peer reader on the sync bus and stand-in for the tag protocol engine.
// Assumes one core clock; the biased bus idles low when nobody drives it.
`timescale 1ns/1ps
module rfs_peer (
	input wire logic core_clk, // Core clock.
	input wire logic iag_start, // IAG sequence start from the block.
	input wire logic sync_out, // Block bus drive level.
	input wire logic sync_oe, // Block bus driver enable.
	input wire logic fire, // Bench request for one peer pulse.
	output logic sync_in, // Resolved bus level.
	output logic prot_done // Protocol engine completion pulse.
);
	int pcnt = 0;
	int dcnt = 0;

	assign sync_in = (sync_oe === 1'b1) ? sync_out : (pcnt > 0);
	assign prot_done = (dcnt == 1);

	// The peer only pulses when the bench asks, so its delay never equals ours.
	always @(posedge core_clk) begin
		if (fire === 1'b1) begin
			pcnt <= 100;
		end else if (pcnt > 0) begin
			pcnt <= pcnt - 1;
		end
		if (iag_start === 1'b1) begin
			dcnt <= 5;
		end else if (dcnt > 0) begin
			dcnt <= dcnt - 1;
		end
	end
endmodule

// ==== tb/test_rfs_ctrl.sv ====
// Self-checking bench for the configuration and sync-bus controller.
// Assumes the peer model on the sync bus and a 100 MHz core clock.
`timescale 1ns/1ps
module test_rfs_ctrl;
	import rfs_pkg::*;
	localparam int MS = 20;
	logic core_clk = 0;
	logic rst_n = 0;
	logic ce = 1;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, sync_in, sync_out, sync_oe, nv_wr, prot_done, perr;
	logic tag_start, iag_start, rf_en, resp_valid;
	logic rf_sensor_req = 0;
	logic nv_ok = 0;
	logic fire = 0;
	logic [8:0] nv_freq = 9'h0aa;
	logic [8:0] nv_wdata, nv_last;
	logic [3:0] resp_code, last_resp;
	rfs_cfg_s cfg;
	int fails = 0;
	int check_count = 0;
	int cyc = 0;
	int resp_cnt = 0;
	int tag_cnt = 0;
	int oe_len = 0;
	int oe_last = 0;
	int n;
	logic [3:0] t_op [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7};
	logic [11:0] t_max [6] = '{RANGE_MAX, ATT_MAX, RANGE_MAX, TOLL_MAX, DELAY_MAX, HOLD_MAX};

	always #5 core_clk = ~core_clk;

	rfs_ctrl #(.MS_CYC(MS)) rfs_ctrl_i (
		.core_clk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .sync_in, .sync_out, .sync_oe, .rf_sensor_req, .nv_freq,
		.nv_ok, .nv_wr, .nv_wdata, .prot_done, .tag_start, .iag_start, .rf_en,
		.resp_valid, .resp_code, .cfg
	);

	rfs_peer rfs_peer_i (
		.core_clk, .iag_start, .sync_out, .sync_oe, .fire, .sync_in, .prot_done
	);

	// ----------------------------------------
	// Monitor and timeout
	// ----------------------------------------
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (resp_valid === 1'b1) begin
			resp_cnt <= resp_cnt + 1;
			last_resp <= resp_code;
		end
		if (nv_wr === 1'b1) begin
			nv_last <= nv_wdata;
		end
		if (tag_start === 1'b1) begin
			tag_cnt <= tag_cnt + 1;
		end
		oe_len <= (sync_oe === 1'b1) ? oe_len + 1 : 0;
		if (sync_oe !== 1'b1 && oe_len != 0) begin
			oe_last <= oe_len;
		end
		if (cyc == 40000) begin
			fails = fails + 1;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cmd(input logic [3:0] op, input logic [11:0] v, input logic [3:0] exp);
		apb(1'b1, OFF_CMD, {12'h000, op, 4'h0, v});
		@(posedge core_clk);
		chk({resp_valid, resp_code}, {1'b1, exp});
	endtask

	task automatic wait_tag();
		do @(posedge core_clk); while (tag_start !== 1'b1);
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge core_clk);
		chk(last_resp, 4'h6);
		chk(rf_en, 1'b0);
		chk(cfg.freq_code, 9'h0aa);
		apb(1'b0, OFF_RANGE, 32'h0000_0000);
		chk(rd, 32'h0000_1f1f);
		apb(1'b0, OFF_ATTEN, 32'h0000_0000);
		chk(rd, 32'h0000_0400);
		apb(1'b0, OFF_SYNC, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b0, 8'h1c, 32'h0000_0000);
		chk(perr, 1'b1);
		n = resp_cnt;
		apb(1'b1, OFF_CTRL, 32'h0000_0005);
		repeat (3) @(posedge core_clk);
		chk(resp_cnt - n, 1);
		chk(last_resp, 4'h6);
		rf_sensor_req <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(resp_cnt - n, 2);
		chk(rf_en, 1'b0);
		cmd(4'h5, 12'h118, resp_done);
		repeat (2) @(posedge core_clk);
		chk(nv_last, 9'h118);
		chk(rf_en, 1'b1);
		cmd(4'h5, 12'h119, resp_error);
		apb(1'b0, OFF_FREQ, 32'h0000_0000);
		chk(rd, 32'h0000_0118);
		for (int i = 0; i < 6; i++) begin
			cmd(t_op[i], t_max[i] + 12'h001, resp_error);
			cmd(t_op[i], t_max[i], resp_done);
		end
		apb(1'b0, OFF_RANGE, 32'h0000_0000);
		chk(rd, 32'h0000_1f1f);
		apb(1'b0, OFF_ATTEN, 32'h0000_0000);
		chk(rd, 32'h0000_0f0a);
		cmd(4'h8, 12'h000, resp_done);
		apb(1'b0, OFF_SYNC, 32'h0000_0000);
		chk(rd, 32'h0000_0aff);
		cmd(4'h9, 12'h000, resp_error);
		cmd(4'h6, 12'h003, resp_done);
		cmd(4'h7, 12'h002, resp_done);
		wait_tag();
		chk(sync_oe, 1'b1);
		chk(sync_out, 1'b1);
		// Ten frozen edges stretch the hold-off by exactly ten cycles.
		ce <= 1'b0;
		repeat (10) @(posedge core_clk);
		ce <= 1'b1;
		n = 10;
		do begin
			@(posedge core_clk);
			n++;
		end while (iag_start !== 1'b1);
		chk(n >= 49 && n <= 51, 1'b1);
		do @(posedge core_clk); while (prot_done !== 1'b1);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (tag_start !== 1'b1);
		chk(n >= 58 && n <= 62, 1'b1);
		do @(posedge core_clk); while (sync_oe === 1'b1);
		@(posedge core_clk);
		chk(oe_last, 100);
		cmd(4'h6, 12'h00a, resp_done);
		wait_tag();
		do @(posedge core_clk); while (sync_oe === 1'b1);
		repeat (20) @(posedge core_clk);
		fire <= 1'b1;
		@(posedge core_clk);
		fire <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (tag_start !== 1'b1);
		chk(n <= 4, 1'b1);
		n = 0;
		repeat (150) begin
			@(posedge core_clk);
			if (sync_oe !== 1'b0) n++;
		end
		chk(n, 0);
		cmd(4'h7, 12'h000, resp_done);
		wait_tag();
		chk(iag_start, 1'b1);
		cmd(4'h6, 12'h000, resp_done);
		repeat (300) @(posedge core_clk);
		n = tag_cnt;
		repeat (300) @(posedge core_clk);
		chk(tag_cnt - n, 0);
		n = resp_cnt;
		rst_n <= 1'b0;
		rf_sensor_req <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(resp_cnt - n, 1);
		chk(last_resp, 4'h6);
		chk(rf_en, 1'b0);
		tally_and_finish();
	end
endmodule
